// file: evtu_pkg.sv
package evtu_pkg;

  // Register word indices on the Avalon-MM word bus (byte address = 4 * index).
  localparam logic [7:0] EVTU_CONTROL_FIRST_IDX   = 8'h00;
  localparam logic [7:0] EVTU_CONTROL_SECOND_IDX   = 8'h01;
  localparam logic [7:0] EVTU_EVENT_CONTROL_REGISTER_IDX  = 8'h04;
  localparam logic [7:0] EVTU_INTCTRL_IDX = 8'h05;
  localparam logic [7:0] EVTU_INTFLAG_IDX = 8'h06;
  localparam logic [7:0] EVTU_STATUS_IDX  = 8'h07;
  localparam logic [7:0] EVTU_CNTL_IDX    = 8'h0A;
  localparam logic [7:0] EVTU_CNTH_IDX    = 8'h0B;
  localparam logic [7:0] EVTU_PWM_PERIOD_BYTE_IDX   = 8'h0C;
  localparam logic [7:0] EVTU_PWM_DUTY_BYTE_IDX   = 8'h0D;

  // Field positions.
  localparam int EVTU_ENABLE_POS  = 0;
  localparam int EVTU_CLOCK_SELECT_FIELD_POS  = 1;
  localparam int EVTU_SYNCRS_POS  = 4;
  localparam int EVTU_MODE_POS    = 0;
  localparam int EVTU_OUTEN_POS   = 4;
  localparam int EVTU_OUTINIT_POS = 5;
  localparam int EVTU_ASYNCHRONOUS_UPDATE_POS   = 6;
  localparam int EVTU_CAPTURE_EVENT_INPUT_ENABLE_POS  = 0;
  localparam int EVTU_EDGE_POS    = 4;
  localparam int EVTU_FILTER_POS  = 6;

  // Reset values.
  localparam logic [7:0]  EVTU_CTRL_RST = 8'h00;
  localparam logic [15:0] EVTU_WORD_RST = 16'h0000;

  // Timing counts.
  localparam int EVTU_FILTER_DEPTH = 4;
  localparam int EVTU_SS_DELAY     = 2;

  // Clock selections.
  localparam logic [1:0] EVTU_PERIPHERAL_CLOCK  = 2'h0;
  localparam logic [1:0] EVTU_CLK_DIV2 = 2'h1;
  localparam logic [1:0] EVTU_CLK_COMP = 2'h2;

  typedef enum logic [2:0] {
    EVTU_PERIODIC = 3'h0,
    EVTU_TIMEOUT  = 3'h1,
    EVTU_CAPTURE  = 3'h2,
    EVTU_FREQ     = 3'h3,
    EVTU_PWIDTH   = 3'h4,
    EVTU_FRQPW    = 3'h5,
    EVTU_SINGLE   = 3'h6,
    EVTU_PWM8     = 3'h7
  } evtu_mode_type;

  // Avalon-MM request bundle.
  typedef struct packed {
    logic [5:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } evtu_avreq_type;

  // Companion timer link bundle.
  typedef struct packed {
    logic tick;
    logic restart;
  } evtu_comp_type;

endpackage : evtu_pkg

// file: evtu_event_timer_unit.sv
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module evtu_event_timer_unit
  import evtu_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic                    mclk_i,
  input  wire logic                    arst_n_i,
  input  wire evtu_pkg::evtu_avreq_type av_req_i,
  output logic [31:0]                  av_readdata_o,
  output logic                         av_waitrequest_o,
  input  wire logic                    event_in_i,
  input  wire evtu_pkg::evtu_comp_type comp_i,
  output logic                         wave_out_o,
  output logic                         event_strobe_o,
  output logic                         irq_o
);
  import evtu_pkg::*;

  // Two-stage reset release; the bus handshake and control registers also clear on the synchronised copy.
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  logic [7:0]       control_first_q, control_second_q, event_control_register_q;
  logic             inten_q, flag_q, run_q;
  logic [CNT_W-1:0] cnt_q, capture_compare_value_q;
  logic [7:0]       temp_q;
  logic             ack_q;

  evtu_mode_type mode;
  logic [1:0]    clock_select_field;
  assign mode   = evtu_mode_type'(control_second_q[EVTU_MODE_POS +: 3]);
  assign clock_select_field = control_first_q[EVTU_CLOCK_SELECT_FIELD_POS +: 2];

  // Bus decode; the slave answers every access one cycle after it is seen.
  // Side effects land only at the edge where waitrequest is sampled low.
  logic [7:0] idx;
  logic       wr_acc, rd_acc;
  assign idx    = {2'b00, av_req_i.address};
  assign wr_acc = av_req_i.write & ack_q;
  assign rd_acc = av_req_i.read & ack_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  logic frozen;
  assign frozen = (mode == EVTU_TIMEOUT) && !run_q;

  // Capture high byte read; ignored in the frozen time-out state.
  logic rd_cap_hi, rd_cnt_lo, wr_flag_clr;
  assign rd_cap_hi   = rd_acc && hit(idx, EVTU_PWM_DUTY_BYTE_IDX) && !frozen;
  assign rd_cnt_lo   = rd_acc && hit(idx, EVTU_CNTL_IDX) && !frozen;
  assign wr_flag_clr = wr_acc && hit(idx, EVTU_INTFLAG_IDX) && av_req_i.writedata[0];

  // Waitrequest drops one cycle after the request, then the request is released.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
    end else if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (av_req_i.read | av_req_i.write) & ~ack_q;
    end
  end
  assign av_waitrequest_o = ~ack_q;

  // Read data mux; the count high byte comes from the temp latched at the low read.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      av_readdata_o <= 32'h0000_0000;
    end else begin
      case (idx)
        EVTU_CONTROL_FIRST_IDX:   av_readdata_o <= {24'h000000, control_first_q};
        EVTU_CONTROL_SECOND_IDX:   av_readdata_o <= {24'h000000, control_second_q};
        EVTU_EVENT_CONTROL_REGISTER_IDX:  av_readdata_o <= {24'h000000, event_control_register_q};
        EVTU_INTCTRL_IDX: av_readdata_o <= {31'h0, inten_q};
        EVTU_INTFLAG_IDX: av_readdata_o <= {31'h0, flag_q};
        EVTU_STATUS_IDX:  av_readdata_o <= {31'h0, run_q};
        EVTU_CNTL_IDX:    av_readdata_o <= {24'h000000, cnt_q[7:0]};
        EVTU_CNTH_IDX:    av_readdata_o <= {24'h000000, temp_q};
        EVTU_PWM_PERIOD_BYTE_IDX:   av_readdata_o <= {24'h000000, capture_compare_value_q[7:0]};
        EVTU_PWM_DUTY_BYTE_IDX:   av_readdata_o <= {24'h000000, capture_compare_value_q[15:8]};
        default:          av_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Software-written control registers.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      control_first_q  <= EVTU_CTRL_RST;
      control_second_q  <= EVTU_CTRL_RST;
      event_control_register_q <= EVTU_CTRL_RST;
      inten_q  <= 1'b0;
      temp_q   <= 8'h00;
    end else if (!rst_n_q) begin
      control_first_q  <= EVTU_CTRL_RST;
      control_second_q  <= EVTU_CTRL_RST;
      event_control_register_q <= EVTU_CTRL_RST;
      inten_q  <= 1'b0;
      temp_q   <= 8'h00;
    end else begin
      if (wr_acc && hit(idx, EVTU_CONTROL_FIRST_IDX))   control_first_q  <= av_req_i.writedata[7:0] & 8'h57;
      if (wr_acc && hit(idx, EVTU_CONTROL_SECOND_IDX))   control_second_q  <= av_req_i.writedata[7:0] & 8'h77;
      if (wr_acc && hit(idx, EVTU_EVENT_CONTROL_REGISTER_IDX))  event_control_register_q <= av_req_i.writedata[7:0] & 8'h51;
      if (wr_acc && hit(idx, EVTU_INTCTRL_IDX)) inten_q  <= av_req_i.writedata[0];
      if (rd_cnt_lo) temp_q <= cnt_q[15:8];
    end
  end

  // Noise filter: the sample only passes after four equal samples.
  logic [EVTU_FILTER_DEPTH-1:0] hist_q;
  logic                         filt_q, ev_prev_q;
  logic                         ev_lvl;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hist_q <= '0;
      filt_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[EVTU_FILTER_DEPTH-2:0], event_in_i};
      if (&hist_q || ~|hist_q) filt_q <= hist_q[0];
    end
  end
  assign ev_lvl = event_control_register_q[EVTU_FILTER_POS] ? filt_q : event_in_i;

  // Edge detection, gated by the event enable.
  logic ev_en, rise, fall, edge_sel, trig;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) ev_prev_q <= 1'b0;
    else           ev_prev_q <= ev_lvl;
  end
  assign ev_en    = event_control_register_q[EVTU_CAPTURE_EVENT_INPUT_ENABLE_POS] && control_first_q[EVTU_ENABLE_POS];
  assign rise     = ev_en && ev_lvl && !ev_prev_q;
  assign fall     = ev_en && !ev_lvl && ev_prev_q;
  assign edge_sel = event_control_register_q[EVTU_EDGE_POS];
  // Edge bit picks the active polarity in time-out, capture and frequency modes: 0 rising, 1 falling.
  assign trig     = edge_sel ? fall : rise;

  // Prescaler tick generation.
  logic div_q, tick;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) div_q <= 1'b0;
    else           div_q <= ~div_q;
  end
  always_comb begin
    case (clock_select_field)
      EVTU_PERIPHERAL_CLOCK:  tick = 1'b1;
      EVTU_CLK_DIV2: tick = div_q;
      EVTU_CLK_COMP: tick = comp_i.tick;
      default:       tick = 1'b0;
    endcase
  end

  logic enable, sync_rs, cnt_wr_lo, cnt_wr_hi, capture_compare_value_wr_lo, capture_compare_value_wr_hi;
  assign enable     = control_first_q[EVTU_ENABLE_POS];
  assign sync_rs    = control_first_q[EVTU_SYNCRS_POS] && comp_i.restart;
  assign cnt_wr_lo  = wr_acc && hit(idx, EVTU_CNTL_IDX);
  assign cnt_wr_hi  = wr_acc && hit(idx, EVTU_CNTH_IDX);
  assign capture_compare_value_wr_lo = wr_acc && hit(idx, EVTU_PWM_PERIOD_BYTE_IDX);
  assign capture_compare_value_wr_hi = wr_acc && hit(idx, EVTU_PWM_DUTY_BYTE_IDX);

  // Single-shot start: one register stage, so run_q rises two cycles after the event and the output one cycle later.
  logic       ss_trig;
  logic       ss_dly_q;
  logic       en_prev_q, pw_phase_q, fp_stage_q, fp_armed_q;
  assign ss_trig = edge_sel ? (rise | fall) : rise;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ss_dly_q  <= 1'b0;
      en_prev_q <= 1'b0;
    end else begin
      ss_dly_q  <= ss_trig && !run_q && mode == EVTU_SINGLE;
      en_prev_q <= enable;
    end
  end

  // Counter, capture register, run state and flag; set wins over clear.
  logic set_flag, at_top, ss_go;
  logic [CNT_W-1:0] top_v;
  assign top_v = capture_compare_value_q;
  assign at_top = (cnt_q == top_v);
  assign ss_go = ss_dly_q;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q      <= EVTU_WORD_RST;
      capture_compare_value_q     <= EVTU_WORD_RST;
      run_q      <= 1'b0;
      flag_q     <= 1'b0;
      pw_phase_q <= 1'b0;
      fp_stage_q <= 1'b0;
      fp_armed_q <= 1'b1;
      set_flag   <= 1'b0;
    end else begin
      set_flag <= 1'b0;
      if (capture_compare_value_wr_lo) capture_compare_value_q[7:0]  <= av_req_i.writedata[7:0];
      if (capture_compare_value_wr_hi) capture_compare_value_q[15:8] <= av_req_i.writedata[7:0];
      if (cnt_wr_lo)  cnt_q[7:0]   <= av_req_i.writedata[7:0];
      if (cnt_wr_hi)  cnt_q[15:8]  <= av_req_i.writedata[7:0];
      if (wr_acc && hit(idx, EVTU_STATUS_IDX) && !frozen) run_q <= av_req_i.writedata[0];
      if (!enable) begin
        run_q <= 1'b0;
      end else if (!(cnt_wr_lo || cnt_wr_hi)) begin
        if (sync_rs) cnt_q <= '0;
        else case (mode)
          EVTU_PERIODIC: begin
            run_q <= 1'b1;
            if (tick) begin
              if (at_top) begin
                cnt_q <= '0;
                set_flag <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          EVTU_TIMEOUT: begin
            if (trig) begin
              if (!run_q || !pw_phase_q) begin
                cnt_q <= '0;
                run_q <= 1'b1;
                pw_phase_q <= 1'b1;
              end else begin
                run_q <= 1'b0;
                pw_phase_q <= 1'b0;
              end
            end else if (tick && run_q) begin
              cnt_q <= cnt_q + 1'b1;
              if (at_top) set_flag <= 1'b1;
            end
          end
          EVTU_CAPTURE: begin
            run_q <= 1'b1;
            if (trig) begin
              capture_compare_value_q <= cnt_q;
              set_flag <= 1'b1;
            end
            if (tick) cnt_q <= cnt_q + 1'b1;
          end
          EVTU_FREQ: begin
            run_q <= 1'b1;
            if (trig) begin
              capture_compare_value_q <= cnt_q;
              cnt_q <= '0;
              set_flag <= 1'b1;
            end else if (tick) cnt_q <= cnt_q + 1'b1;
          end
          EVTU_PWIDTH: begin
            run_q <= 1'b1;
            if (!pw_phase_q && rise) begin
              cnt_q <= '0;
              pw_phase_q <= 1'b1;
            end else if (pw_phase_q && fall) begin
              capture_compare_value_q <= cnt_q;
              set_flag <= 1'b1;
              pw_phase_q <= 1'b0;
            end else if (tick) cnt_q <= cnt_q + 1'b1;
          end
          EVTU_FRQPW: begin
            if (fp_armed_q && rise && !run_q) begin
              cnt_q <= '0;
              run_q <= 1'b1;
              fp_stage_q <= 1'b0;
            end else if (run_q && !fp_stage_q && fall) begin
              capture_compare_value_q <= cnt_q;
              fp_stage_q <= 1'b1;
            end else if (run_q && fp_stage_q && rise) begin
              run_q <= 1'b0;
              set_flag <= 1'b1;
              fp_armed_q <= 1'b0;
            end else if (tick && run_q) cnt_q <= cnt_q + 1'b1;
            if (rd_cap_hi || wr_flag_clr) fp_armed_q <= 1'b1;
          end
          EVTU_SINGLE: begin
            if (enable && !en_prev_q && cnt_q != top_v) run_q <= 1'b1;
            if (ss_go && !run_q) begin
              cnt_q <= '0;
              run_q <= 1'b1;
            end else if (run_q && tick) begin
              if (at_top) run_q <= 1'b0;
              else cnt_q <= cnt_q + 1'b1;
            end
          end
          default: begin
            run_q <= 1'b1;
            if (tick) begin
              if (cnt_q[7:0] >= capture_compare_value_q[7:0]) cnt_q <= '0;
              else cnt_q <= cnt_q + 1'b1;
            end
          end
        endcase
      end
      // Set has priority over clear.
      if (set_flag) flag_q <= 1'b1;
      else if (wr_flag_clr) flag_q <= 1'b0;
      else if (rd_cap_hi && (mode inside {EVTU_CAPTURE, EVTU_FREQ, EVTU_PWIDTH, EVTU_FRQPW}))
        flag_q <= 1'b0;
    end
  end

  // Event strobe and interrupt request, both registered.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      event_strobe_o <= 1'b0;
      irq_o          <= 1'b0;
    end else begin
      event_strobe_o <= set_flag;
      irq_o          <= (flag_q | set_flag) && inten_q;
    end
  end

  // Waveform output selection per mode.
  logic [7:0] per_b, duty_b;
  logic       pwm_lvl;
  assign per_b  = capture_compare_value_q[7:0];
  assign duty_b = capture_compare_value_q[15:8];
  // Compare on the value about to be shown, so output tracks the counter.
  assign pwm_lvl = (per_b != 8'h00) && (duty_b != 8'h00) &&
                   ((duty_b == per_b + 8'h01) || (cnt_q[7:0] < duty_b));
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wave_out_o <= 1'b0;
    end else if (!control_second_q[EVTU_OUTEN_POS]) begin
      wave_out_o <= 1'b0;
    end else begin
      case (mode)
        EVTU_SINGLE: wave_out_o <= run_q || (control_second_q[EVTU_ASYNCHRONOUS_UPDATE_POS] && ss_trig);
        EVTU_PWM8:   wave_out_o <= enable && pwm_lvl;
        default:     wave_out_o <= control_second_q[EVTU_OUTINIT_POS];
      endcase
    end
  end

  // Periodic flag fires on every tick at equality.
  property p_periodic_flag;
    @(posedge mclk_i) disable iff (!rst_n_q)
      (mode == EVTU_PERIODIC && enable && tick && at_top && !cnt_wr_lo && !cnt_wr_hi
       && !sync_rs) |=> set_flag;
  endproperty
  a_periodic_flag: assert property (p_periodic_flag) else $error("periodic flag missing");

  property p_strobe;
    @(posedge mclk_i) disable iff (!rst_n_q)
      event_strobe_o |-> flag_q;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without flag");

  property p_irq;
    @(posedge mclk_i) disable iff (!rst_n_q)
      (flag_q && inten_q) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_cap_clear;
    @(posedge mclk_i) disable iff (!rst_n_q)
      (rd_cap_hi && mode == EVTU_CAPTURE && !set_flag) |=> !flag_q;
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("flag not cleared on read");

  property p_wave_init;
    @(posedge mclk_i) disable iff (!rst_n_q)
      (control_second_q[EVTU_OUTEN_POS] && mode == EVTU_CAPTURE) [*2] |-> wave_out_o ==
        $past(control_second_q[EVTU_OUTINIT_POS]);
  endproperty
  a_wave_init: assert property (p_wave_init) else $error("output not initial value");

  property p_ss_delay;
    @(posedge mclk_i) disable iff (!rst_n_q)
      (mode == EVTU_SINGLE && !control_second_q[EVTU_ASYNCHRONOUS_UPDATE_POS] && ss_dly_q && !run_q
       && enable && !cnt_wr_lo && !cnt_wr_hi && !sync_rs) |=> run_q;
  endproperty
  a_ss_delay: assert property (p_ss_delay) else $error("single shot start late");

  property p_freq_cap;
    @(posedge mclk_i) disable iff (!rst_n_q)
      (mode == EVTU_FREQ && enable && trig && !cnt_wr_lo && !cnt_wr_hi && !sync_rs
       && !capture_compare_value_wr_lo && !capture_compare_value_wr_hi) |=> (capture_compare_value_q == $past(cnt_q)) && cnt_q == '0;
  endproperty
  a_freq_cap: assert property (p_freq_cap) else $error("frequency capture wrong");

  property p_filter;
    @(posedge mclk_i) disable iff (!rst_n_q)
      (filt_q != $past(filt_q)) |-> (&$past(hist_q) || ~|$past(hist_q));
  endproperty
  a_filter: assert property (p_filter) else $error("filter passed unstable input");

endmodule : evtu_event_timer_unit

`default_nettype wire

// file: evtu_comp_model.sv
`timescale 1ns/1ps
`default_nettype none
module evtu_comp_model
  import evtu_pkg::*;
#(
  parameter int DIV = 4,
  parameter int TOP = 9
) (
  input  wire logic                   mclk_i,
  input  wire logic                   arst_n_i,
  output var evtu_pkg::evtu_comp_type comp_o
);
  logic [7:0] pre_q;
  logic [7:0] cnt_q;
  logic       tick;

  // One tick every DIV cycles stands in for the companion's prescaled clock.
  assign tick = (pre_q == 8'(DIV - 1));

  // Prescaler count.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) pre_q <= 8'h00;
    else pre_q <= tick ? 8'h00 : pre_q + 8'h01;
  end

  // Counter wraps at TOP, so restart pulses keep coming for the whole run.
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_q <= 8'h00;
    else if (tick) cnt_q <= (cnt_q == 8'(TOP)) ? 8'h00 : cnt_q + 8'h01;
  end

  // The restart rides on the wrapping tick, as a real prescaled counter does.
  assign comp_o = '{tick: tick, restart: tick && (cnt_q == 8'(TOP))};
endmodule : evtu_comp_model
`default_nettype wire

// file: evtu_event_timer_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module evtu_event_timer_unit_tb_top;
  import evtu_pkg::*;
  localparam int DIV = 4;
  logic           mclk_i = 1'b0;
  logic           arst_n_i = 1'b0;
  logic           event_in_i = 1'b0;
  evtu_avreq_type req = '0;
  evtu_comp_type  comp;
  logic [31:0]    rdata;
  logic           wait_o, wave, strb, irq;
  logic [7:0]     v, lo, hi;
  int             errors = 0, n_checks = 0, cyc = 0, seed = 32'h742bdb74;
  int             top, n, d, w, p, h, dv;
  int             sq[$];
  int             pl[5] = '{5, 5, 5, 0, 9};
  int             ph[5] = '{0, 3, 6, 2, 0};
  logic [7:0]     ra[6] = '{EVTU_CONTROL_FIRST_IDX, EVTU_CONTROL_SECOND_IDX, EVTU_EVENT_CONTROL_REGISTER_IDX,
                            EVTU_INTFLAG_IDX, EVTU_PWM_PERIOD_BYTE_IDX, 8'h02};

  // Clock at 40 MHz.
  always #12.5 mclk_i = ~mclk_i;

  evtu_event_timer_unit u_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .av_req_i(req),
    .av_readdata_o(rdata), .av_waitrequest_o(wait_o), .event_in_i(event_in_i),
    .comp_i(comp), .wave_out_o(wave), .event_strobe_o(strb), .irq_o(irq));
  evtu_comp_model #(.DIV(DIV)) u_comp (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .comp_o(comp));

  // Cycle count, strobe log and hang guard.
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (strb === 1'b1) sq.push_back(cyc);
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  // Expected high cycles per PWM period; a duty past the period holds high.
  function automatic int pwm_exp(input int l, input int hh);
    return (l == 0 || hh == 0) ? 0 : (hh > l) ? l + 1 : hh;
  endfunction : pwm_exp

  // Avalon write: request held until waitrequest is seen low at an edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] dd);
    @(posedge mclk_i);
    req <= '{a[5:0], 1'b0, 1'b1, {24'h0, dd}};
    do @(posedge mclk_i); while (wait_o !== 1'b0);
    req <= '0;
  endtask : wr

  // Avalon read: data taken at the same edge that ends the wait.
  task automatic rd(input logic [7:0] a, output logic [7:0] dd);
    @(posedge mclk_i);
    req <= '{a[5:0], 1'b1, 1'b0, 32'h0};
    do @(posedge mclk_i); while (wait_o !== 1'b0);
    dd = rdata[7:0];
    req <= '0;
  endtask : rd

  // Event level change, then c cycles in total at that level.
  task automatic ev(input logic lv, input int c);
    @(posedge mclk_i);
    event_in_i <= lv;
    repeat (c - 1) @(posedge mclk_i);
  endtask : ev

  // Waits for k strobes, with a bound.
  task automatic ws(input int k);
    int t;
    t = 0;
    while (sq.size() < k && t < 500) begin
      @(posedge mclk_i);
      t++;
    end
  endtask : ws

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    foreach (ra[i]) begin
      rd(ra[i], v);
      `CHK(v, 8'h00)
    end
    $display("reset values done");
    // Periodic mode: strobe spacing is the compare value plus one.
    top = 10 + ($random(seed) & 7);
    wr(EVTU_PWM_PERIOD_BYTE_IDX, 8'(top));
    wr(EVTU_PWM_DUTY_BYTE_IDX, 8'h00);
    wr(EVTU_INTCTRL_IDX, 8'h01);
    sq.delete();
    wr(EVTU_CONTROL_FIRST_IDX, 8'h01);
    ws(1);
    @(posedge mclk_i);
    `CHK(irq, 1'b1)
    wr(EVTU_INTFLAG_IDX, 8'h01);
    repeat (2) @(posedge mclk_i);
    `CHK(irq, 1'b0)
    ws(2);
    `CHK(sq.size() >= 2 ? sq[1] - sq[0] : 0, top + 1)
    wr(EVTU_CONTROL_FIRST_IDX, 8'h00);
    wr(EVTU_CONTROL_SECOND_IDX, 8'h30);
    repeat (3) @(posedge mclk_i);
    `CHK(wave, 1'b1)
    wr(EVTU_CONTROL_SECOND_IDX, 8'h10);
    repeat (3) @(posedge mclk_i);
    `CHK(wave, 1'b0)
    $display("periodic done");
    // PWM: software stops, loads both bytes, zeroes the count, restarts.
    ph[4] = 1 + (($random(seed) & 32'h7FFF) % 9);
    foreach (pl[i]) begin
      wr(EVTU_CONTROL_FIRST_IDX, 8'h00);
      wr(EVTU_PWM_PERIOD_BYTE_IDX, 8'(pl[i]));
      wr(EVTU_PWM_DUTY_BYTE_IDX, 8'(ph[i]));
      wr(EVTU_CNTL_IDX, 8'h00);
      wr(EVTU_CNTH_IDX, 8'h00);
      wr(EVTU_CONTROL_SECOND_IDX, 8'h17);
      wr(EVTU_CONTROL_FIRST_IDX, 8'h01);
      repeat (2 * pl[i] + 6) @(posedge mclk_i);
      h = 0;
      repeat (pl[i] + 1) begin
        @(posedge mclk_i);
        h += (wave === 1'b1);
      end
      `CHK(h, pwm_exp(pl[i], ph[i]))
    end
    $display("pwm done");
    // Single shot, with the count preloaded to TOP so enabling alone stays idle.
    n = 8 + ($random(seed) & 7);
    wr(EVTU_CONTROL_FIRST_IDX, 8'h00);
    wr(EVTU_PWM_PERIOD_BYTE_IDX, 8'(n));
    wr(EVTU_PWM_DUTY_BYTE_IDX, 8'h00);
    wr(EVTU_CNTL_IDX, 8'(n));
    wr(EVTU_CNTH_IDX, 8'h00);
    wr(EVTU_EVENT_CONTROL_REGISTER_IDX, 8'h01);
    wr(EVTU_CONTROL_SECOND_IDX, 8'h16);
    wr(EVTU_CONTROL_FIRST_IDX, 8'h01);
    repeat (6) @(posedge mclk_i);
    `CHK(wave, 1'b0)
    ev(1'b1, 1);
    d = 0;
    do begin
      @(posedge mclk_i);
      d++;
    end while (wave !== 1'b1 && d < 8);
    `CHK(d, EVTU_SS_DELAY + 2)
    w = 0;
    while (wave === 1'b1 && w < 40) begin
      @(posedge mclk_i);
      w++;
    end
    `CHK(w >= n - 1 && w <= n + 2, 1'b1)
    ev(1'b0, 6);
    `CHK(wave, 1'b0)
    $display("single shot done");
    // Frequency: edges held many cycles so the input is always seen.
    p = 20 + ($random(seed) & 15);
    wr(EVTU_CONTROL_FIRST_IDX, 8'h00);
    wr(EVTU_CNTL_IDX, 8'h00);
    wr(EVTU_CNTH_IDX, 8'h00);
    wr(EVTU_CONTROL_SECOND_IDX, 8'h03);
    wr(EVTU_CONTROL_FIRST_IDX, 8'h01);
    ev(1'b1, p / 2);
    ev(1'b0, p - p / 2);
    ev(1'b1, p / 2);
    ev(1'b0, p - p / 2);
    ev(1'b1, 1);
    rd(EVTU_INTFLAG_IDX, v);
    `CHK(v[0], 1'b1)
    rd(EVTU_PWM_PERIOD_BYTE_IDX, lo);
    rd(EVTU_PWM_DUTY_BYTE_IDX, hi);
    `CHK({hi, lo} >= p - 1 && {hi, lo} <= p + 1, 1'b1)
    rd(EVTU_INTFLAG_IDX, v);
    `CHK(v[0], 1'b0)
    $display("frequency done");
    // Pulse width: restart on the rise, capture on the fall.
    wr(EVTU_CONTROL_FIRST_IDX, 8'h00);
    wr(EVTU_CONTROL_SECOND_IDX, 8'h04);
    wr(EVTU_CONTROL_FIRST_IDX, 8'h01);
    ev(1'b0, 3);
    ev(1'b1, p);
    ev(1'b0, 3);
    rd(EVTU_PWM_PERIOD_BYTE_IDX, lo);
    rd(EVTU_PWM_DUTY_BYTE_IDX, hi);
    `CHK({hi, lo} >= p - 1 && {hi, lo} <= p + 1, 1'b1)
    $display("pulse width done");
    // Divided and companion clocks over a fixed span.
    for (int j = 0; j < 2; j++) begin
      dv = j ? DIV : 2;
      wr(EVTU_CONTROL_FIRST_IDX, 8'h00);
      wr(EVTU_CNTL_IDX, 8'h00);
      wr(EVTU_CNTH_IDX, 8'h00);
      wr(EVTU_PWM_PERIOD_BYTE_IDX, 8'hFF);
      wr(EVTU_PWM_DUTY_BYTE_IDX, 8'hFF);
      wr(EVTU_CONTROL_SECOND_IDX, 8'h00);
      wr(EVTU_CONTROL_FIRST_IDX, j ? 8'h05 : 8'h03);
      repeat (80) @(posedge mclk_i);
      wr(EVTU_CONTROL_FIRST_IDX, 8'h00);
      rd(EVTU_CNTL_IDX, lo);
      rd(EVTU_CNTH_IDX, hi);
      `CHK({hi, lo} >= 80 / dv - 1 && {hi, lo} <= 80 / dv + 2, 1'b1)
    end
    $display("clock select done");
    test_done();
  end
endmodule : evtu_event_timer_unit_tb_top
`default_nettype wire
